// >>> irs_pkg.sv
package irs_pkg;
	localparam logic [6:0] IRS_DEV_ADDR = 7'h57;
	localparam logic [7:0] IRS_FIFO_ADDR = 8'h07;
	localparam logic [7:0] IRS_PTR_RST = 8'h00;
	localparam logic [7:0] IRS_BYTE_RST = 8'h00;
	localparam logic [3:0] IRS_CNT_RST = 4'h0;
	localparam logic [3:0] IRS_BYTE_BITS = 4'h8;
	localparam logic [3:0] IRS_RW_IDX = 4'h7;
	localparam logic [3:0] IRS_ADDR_MSB = 4'h6;
	localparam logic [3:0] IRS_BIT_MSB = 4'h7;
	localparam logic IRS_LINE_IDLE = 1'b1;
	localparam logic [1:0] IRS_SYNC_RST = 2'h3;
	typedef enum logic [2:0] {
		irs_st_idle = 3'b000,
		irs_st_addr = 3'b001,
		irs_st_write = 3'b010,
		irs_st_read = 3'b011,
		irs_st_skip = 3'b100
	} irs_state_e;
endpackage : irs_pkg

// >>> irs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module irs_sync
	import irs_pkg::*;
#(
	parameter int unsigned W = 2,
	parameter logic [W-1:0] RST = '1
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta <= RST;
			q <= RST;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : irs_sync
`default_nettype wire

// >>> irs_cond.sv
`timescale 1ns/1ns
`default_nettype none
module irs_cond
	import irs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic scl_s,
	input wire logic sda_s,
	output logic scl_hi,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_c,
	output logic stop_c
);
	logic scl_p;
	logic sda_p;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			scl_p <= IRS_LINE_IDLE;
			sda_p <= IRS_LINE_IDLE;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	// Both lines share one synchroniser, so their skew stays fixed
	always_comb begin
		scl_hi = scl_s;
		scl_rise = scl_s & ~scl_p;
		scl_fall = ~scl_s & scl_p;
		start_c = scl_s & scl_p & sda_p & ~sda_s;
		stop_c = scl_s & scl_p & ~sda_p & sda_s;
	end
endmodule : irs_cond
`default_nettype wire

// >>> irs_slave.sv
`timescale 1ns/1ns
`default_nettype none
module irs_slave
	import irs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic [7:0] reg_wr_data,
	output logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	output logic fifo_pop,
	output logic busy
);
	logic scl_s;
	logic sda_s;
	logic scl_hi;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	irs_state_e state;
	irs_state_e next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic ack_ph;
	logic next_ack_ph;
	logic rw;
	logic next_rw;
	logic first;
	logic next_first;
	logic start_hi;
	logic next_start_hi;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic next_sda_oe;
	logic [7:0] next_reg_addr;
	logic next_reg_wr_en;
	logic [7:0] next_reg_wr_data;
	logic next_reg_rd_en;
	logic next_fifo_pop;
	logic next_busy;

	irs_sync #(
		.W(2),
		.RST(IRS_SYNC_RST)
	) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.d({scl_in, sda_in}),
		.q({scl_s, sda_s})
	);

	irs_cond u_cond (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_hi(scl_hi),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_c(start_c),
		.stop_c(stop_c)
	);

	// Open drain: the pin only ever pulls low, scl is never driven
	assign sda_out = 1'b0;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_ack_ph = ack_ph;
		next_rw = rw;
		next_first = first;
		next_shreg = shreg;
		next_sda_oe = sda_oe;
		next_reg_addr = reg_addr;
		next_reg_wr_en = 1'b0;
		next_reg_wr_data = reg_wr_data;
		next_reg_rd_en = 1'b0;
		next_fifo_pop = 1'b0;
		next_start_hi = start_hi;
		// Read data must be valid in the strobe cycle; it is caught here
		if (reg_rd_en) begin
			next_shreg = reg_rd_data;
			if (reg_addr != IRS_FIFO_ADDR) begin
				next_reg_addr = 8'(reg_addr + 8'h01);
			end
		end
		if (start_c) begin
			next_start_hi = 1'b1;
		end else if (!scl_hi) begin
			// Any low clock closes the start's own high phase
			next_start_hi = 1'b0;
		end
		if (start_c) begin
			// Repeated start keeps the pointer
			next_state = irs_st_addr;
			next_cnt = IRS_CNT_RST;
			next_ack_ph = 1'b0;
			next_sda_oe = 1'b0;
		end else if (stop_c && !start_hi) begin
			next_state = irs_st_idle;
			next_cnt = IRS_CNT_RST;
			next_ack_ph = 1'b0;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				irs_st_idle: begin
					next_sda_oe = 1'b0;
				end
				irs_st_skip: begin
					next_sda_oe = 1'b0;
				end
				irs_st_addr: begin
					if (scl_rise && !ack_ph) begin
						next_shreg = {shreg[6:0], sda_s};
						next_cnt = 4'(cnt + 4'h1);
						if (cnt < IRS_RW_IDX) begin
							if (sda_s != IRS_DEV_ADDR[3'(IRS_ADDR_MSB - cnt)]) begin
								next_state = irs_st_skip;
							end
						end else begin
							next_rw = sda_s;
						end
					end else if (scl_rise && ack_ph && rw) begin
						next_reg_rd_en = 1'b1;
						next_fifo_pop = (reg_addr == IRS_FIFO_ADDR);
					end else if (scl_fall && !ack_ph && cnt == IRS_BYTE_BITS) begin
						next_ack_ph = 1'b1;
						next_sda_oe = 1'b1;
					end else if (scl_fall && ack_ph) begin
						next_ack_ph = 1'b0;
						next_cnt = IRS_CNT_RST;
						if (rw) begin
							next_state = irs_st_read;
							next_sda_oe = ~shreg[7];
						end else begin
							next_state = irs_st_write;
							next_first = 1'b1;
							next_sda_oe = 1'b0;
						end
					end
				end
				irs_st_write: begin
					if (scl_rise && !ack_ph) begin
						next_shreg = {shreg[6:0], sda_s};
						next_cnt = 4'(cnt + 4'h1);
					end else if (scl_fall && !ack_ph && cnt == IRS_BYTE_BITS) begin
						next_ack_ph = 1'b1;
						next_sda_oe = 1'b1;
						if (first) begin
							next_reg_addr = shreg;
						end else begin
							next_reg_wr_en = 1'b1;
							next_reg_wr_data = shreg;
						end
					end else if (scl_fall && ack_ph) begin
						next_ack_ph = 1'b0;
						next_cnt = IRS_CNT_RST;
						next_sda_oe = 1'b0;
						if (first) begin
							next_first = 1'b0;
						end else begin
							next_reg_addr = 8'(reg_addr + 8'h01);
						end
					end
				end
				irs_st_read: begin
					if (scl_rise && !ack_ph) begin
						next_cnt = 4'(cnt + 4'h1);
					end else if (scl_fall && !ack_ph) begin
						if (cnt == IRS_BYTE_BITS) begin
							next_ack_ph = 1'b1;
							next_sda_oe = 1'b0;
						end else begin
							next_sda_oe = ~shreg[3'(IRS_BIT_MSB - cnt)];
						end
					end else if (scl_rise && ack_ph) begin
						if (!sda_s) begin
							next_reg_rd_en = 1'b1;
							next_fifo_pop = (reg_addr == IRS_FIFO_ADDR);
						end else begin
							// Not acknowledged: stay off the bus until STOP or START
							next_state = irs_st_skip;
							next_ack_ph = 1'b0;
						end
					end else if (scl_fall && ack_ph) begin
						next_ack_ph = 1'b0;
						next_cnt = IRS_CNT_RST;
						next_sda_oe = ~shreg[7];
					end
				end
				default: begin
					next_state = irs_st_idle;
					next_sda_oe = 1'b0;
				end
			endcase
		end
		next_busy = (next_state == irs_st_write) || (next_state == irs_st_read);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= irs_st_idle;
			cnt <= IRS_CNT_RST;
			ack_ph <= 1'b0;
			rw <= 1'b0;
			first <= 1'b0;
			start_hi <= 1'b0;
			shreg <= IRS_BYTE_RST;
			sda_oe <= 1'b0;
			reg_addr <= IRS_PTR_RST;
			reg_wr_en <= 1'b0;
			reg_wr_data <= IRS_BYTE_RST;
			reg_rd_en <= 1'b0;
			fifo_pop <= 1'b0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ack_ph <= next_ack_ph;
			rw <= next_rw;
			first <= next_first;
			start_hi <= next_start_hi;
			shreg <= next_shreg;
			sda_oe <= next_sda_oe;
			reg_addr <= next_reg_addr;
			reg_wr_en <= next_reg_wr_en;
			reg_wr_data <= next_reg_wr_data;
			reg_rd_en <= next_reg_rd_en;
			fifo_pop <= next_fifo_pop;
			busy <= next_busy;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	start_enter_a: assert property (
		start_c |=> state == irs_st_addr && cnt == IRS_CNT_RST && !sda_oe
	) else $error("start not taken");

	stop_abort_a: assert property (
		stop_c && !start_hi && !start_c |=> state == irs_st_idle && !sda_oe
	) else $error("stop did not abort");

	stop_same_high_a: assert property (
		stop_c && start_hi && !start_c && state == irs_st_addr
		|=> state == irs_st_addr
	) else $error("stop in start high phase honoured");

	rep_start_a: assert property (
		start_c && busy && !reg_rd_en
		|=> state == irs_st_addr && reg_addr == $past(reg_addr)
	) else $error("repeated start lost pointer");

	addr_miss_a: assert property (
		state == irs_st_addr && scl_rise && !ack_ph && !start_c && !stop_c
		&& cnt < IRS_RW_IDX
		&& sda_s != IRS_DEV_ADDR[3'(IRS_ADDR_MSB - cnt)]
		|=> state == irs_st_skip
	) else $error("address mismatch not dropped");

	skip_quiet_a: assert property (
		state == irs_st_skip |-> !sda_oe && !reg_wr_en && !busy
	) else $error("skipped transfer touched bus");

	addr_ack_a: assert property (
		state == irs_st_addr && scl_fall && !ack_ph && !start_c && !stop_c
		&& cnt == IRS_BYTE_BITS
		|=> sda_oe && ack_ph
	) else $error("address not acknowledged");

	rw_dir_a: assert property (
		state == irs_st_addr && ack_ph && scl_fall && !start_c && !stop_c
		|=> state == ($past(rw) ? irs_st_read : irs_st_write)
	) else $error("direction bit ignored");

	write_ack_a: assert property (
		state == irs_st_write && ack_ph |-> sda_oe
	) else $error("write byte not acknowledged");

	wr_advance_a: assert property (
		state == irs_st_write && ack_ph && scl_fall && !first
		&& !start_c && !stop_c
		|=> reg_addr == 8'($past(reg_addr) + 8'h01) && !sda_oe
	) else $error("write pointer did not step");

	rd_advance_a: assert property (
		reg_rd_en && reg_addr != IRS_FIFO_ADDR
		|=> reg_addr == 8'($past(reg_addr) + 8'h01)
		&& shreg == $past(reg_rd_data)
	) else $error("read pointer did not step");

	fifo_hold_a: assert property (
		reg_rd_en && reg_addr == IRS_FIFO_ADDR
		|-> fifo_pop ##1 reg_addr == $past(reg_addr)
	) else $error("queue register pointer moved");

	rd_first_bit_a: assert property (
		state == irs_st_read && ack_ph && scl_fall && !start_c && !stop_c
		|=> sda_oe == !$past(shreg[7]) && !ack_ph
	) else $error("read bit not driven after ack");
endmodule : irs_slave
`default_nettype wire

// >>> irs_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module irs_ctrl_model
	import irs_pkg::*;
(
	output var logic scl,
	output var logic pull_low,
	input wire logic sda
);
	localparam int Q = 20;
	initial begin
		scl = IRS_LINE_IDLE;
		pull_low = 1'b0;
	end
	task automatic send_bit(input logic v);
		pull_low = ~v;
		#Q scl = 1'b1;
		#(2*Q) scl = 1'b0;
		#Q;
	endtask : send_bit
	// Sampled mid-high, well after the device has moved its bit
	task automatic sense_bit(output logic v);
		pull_low = 1'b0;
		#Q scl = 1'b1;
		#Q v = sda;
		#Q scl = 1'b0;
		#Q;
	endtask : sense_bit
	// Start ends with scl low, so no stop falls in its high phase; stop leaves scl high for the next start
	task automatic start;
		pull_low = 1'b0;
		#Q scl = 1'b1;
		#Q pull_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask : start
	task automatic stop;
		pull_low = 1'b1;
		#Q scl = 1'b1;
		#Q pull_low = 1'b0;
		#(2*Q);
	endtask : stop
	task automatic put_byte(input logic [7:0] b, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			send_bit(b[i]);
		end
		sense_bit(ack_n);
	endtask : put_byte
	task automatic get_byte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sense_bit(b[i]);
		end
		send_bit(last);
	endtask : get_byte
endmodule : irs_ctrl_model
`default_nettype wire

// >>> i2c_register_access_slave_test.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_register_access_slave_test
	import irs_pkg::*;
;
	logic clk_sys, arst_n, scl, pull_low, ack_n;
	wire logic sda_out, sda_oe, reg_wr_en, reg_rd_en, fifo_pop, busy, sda_line;
	wire logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic [7:0] bank [256];
	logic [7:0] exp_bank [256];
	logic [7:0] fifo_cnt, fifo_exp, p;
	logic [31:0] r;
	int error_cnt, comparisons, seed;
	assign sda_line = ~(pull_low | (sda_oe & ~sda_out));
	function automatic logic [7:0] fifo_val(input logic [7:0] n);
		return n * 8'h03 + 8'h5A;
	endfunction : fifo_val
	// Register side answers combinationally, as the strobes expect
	assign reg_rd_data = (reg_addr === IRS_FIFO_ADDR) ? fifo_val(fifo_cnt) :
		bank[reg_addr];
	always @(posedge clk_sys) begin
		if (reg_wr_en) bank[reg_addr] <= reg_wr_data;
		if (fifo_pop) fifo_cnt <= fifo_cnt + 8'h01;
	end
	irs_slave u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.fifo_pop(fifo_pop), .busy(busy));
	irs_ctrl_model u_ctrl (.scl(scl), .pull_low(pull_low), .sda(sda_line));
	always #2 clk_sys = ~clk_sys;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic open_ptr(input logic [7:0] ptr);
		@(posedge clk_sys);
		#1;
		u_ctrl.start();
		u_ctrl.put_byte({IRS_DEV_ADDR, 1'b0}, ack_n);
		check({7'h00, ack_n}, 8'h00);
		u_ctrl.put_byte(ptr, ack_n);
		check({7'h00, ack_n}, 8'h00);
	endtask : open_ptr
	task automatic wr_burst(input logic [7:0] ptr, input int n);
		open_ptr(ptr);
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			u_ctrl.put_byte(r[7:0], ack_n);
			check({7'h00, ack_n}, 8'h00);
			exp_bank[ptr + i[7:0]] = r[7:0];
		end
		check({7'h00, busy}, 8'h01);
		u_ctrl.stop();
		check({7'h00, busy}, 8'h00);
	endtask : wr_burst
	task automatic rd_burst(input logic [7:0] ptr, input int n);
		logic [7:0] a, b;
		open_ptr(ptr);
		u_ctrl.start();
		u_ctrl.put_byte({IRS_DEV_ADDR, 1'b1}, ack_n);
		check({7'h00, ack_n}, 8'h00);
		a = ptr;
		for (int i = 0; i < n; i++) begin
			u_ctrl.get_byte(i == n - 1, b);
			if (a === IRS_FIFO_ADDR) begin
				check(b, fifo_val(fifo_exp));
				fifo_exp++;
			end else begin
				check(b, exp_bank[a]);
				a++;
			end
		end
		u_ctrl.stop();
	endtask : rd_burst
	initial begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		seed = 32'hCADFFACD;
		fifo_cnt = 8'h00;
		fifo_exp = 8'h00;
		for (int i = 0; i < 256; i++) begin
			r = $random(seed);
			bank[i] = r[7:0];
			exp_bank[i] = r[7:0];
		end
		repeat (12) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		repeat (5) @(posedge clk_sys);
		check({6'h00, busy, sda_oe}, 8'h00);
		check(reg_addr, IRS_PTR_RST);
		$display("test reset done");
		// Write burst runs across the sample queue register; the read burst stops on it
		wr_burst(8'h05, 4);
		rd_burst(8'h03, 7);
		check(reg_addr, IRS_FIFO_ADDR);
		check({7'h00, sda_out}, 8'h00);
		$display("test burst done");
		for (int k = 0; k < 7; k++) begin
			@(posedge clk_sys);
			#1;
			u_ctrl.start();
			u_ctrl.put_byte({IRS_DEV_ADDR ^ (7'h01 << k), 1'b0}, ack_n);
			check({7'h00, ack_n}, 8'h01);
			u_ctrl.put_byte(8'h10, ack_n);
			check({7'h00, ack_n}, 8'h01);
			u_ctrl.stop();
		end
		wr_burst(8'h10, 2);
		rd_burst(8'h10, 2);
		$display("test address done");
		// Abort in mid-byte must leave the target register alone
		open_ptr(8'h20);
		for (int i = 0; i < 4; i++) begin
			u_ctrl.send_bit(1'b1);
		end
		u_ctrl.stop();
		check({7'h00, busy}, 8'h00);
		rd_burst(8'h20, 1);
		$display("test abort done");
		repeat (6) begin
			r = $random(seed);
			p = {4'h0, r[3:0]};
			wr_burst(p, 1 + r[5:4]);
			rd_burst(p, 2 + r[5:4]);
		end
		rd_burst(IRS_FIFO_ADDR, 4);
		$display("test random done");
		give_verdict();
	end
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end
endmodule : i2c_register_access_slave_test
`default_nettype wire
